// ===== verilog/fpx_defines.svh
// Bit positions, masks and reset values for the exception and control block
`ifndef FPX_DEFINES_SVH
`define FPX_DEFINES_SVH
`define FLG_INV        0
`define FLG_DVZ        1
`define FLG_OFL        2
`define FLG_UFL        3
`define FLG_INX        4
`define FLG_W          5
`define STAT_FLAGS_MSB 4
`define STAT_AC_BIT    12
`define STAT_TRAP_LSB  16
`define STAT_TRAP_MSB  20
`define STAT_WMASK     32'h001F_101F
`define STAT_RESET     32'h0000_0000
`define LCR_WMASK      32'h0000_00F7
`define LCR_RESET      32'h0000_0000
`define LCR_PR_BIT     7
`define LCR_AS_BIT     2
`define LCR_EX_BIT     1
`define LCR_OFF_BIT    0
`define ACR_EN_BIT     8
`define ACR_SB_BIT     11
`define ACR_AB_BIT     10
`define ACR_RE_BIT     9
`define ACR_RU_BIT     31
`define ACR_IE_BIT     28
`define ACR_MO_BIT     27
`define ACR_EO_BIT     26
`define ACR_RESET      32'h0000_0000
`define ACR_WMASK      32'h0000_0100
`define ACR_SB_AB_MASK 32'h0000_0C00
`define ACR_STAT_MASK  32'h9CFF_F6FF
`endif

// ===== verilog/fpx_pkg.sv
// Types for the exception and control block; only word_t and cmd_e are used by both ends
package fpx_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_READ_STATUS, OP_WRITE_STATUS,
    OP_READ_CONTROL, OP_WRITE_CONTROL
  } cmd_e;
  typedef enum logic [1:0] {CMP_LT, CMP_EQ, CMP_GT, CMP_UN} cmp_e;
  typedef struct packed {
    logic trap_nan; logic inf_sub; logic zero_x_inf; logic div_indet;
    logic rem_bad; logic sqrt_neg; logic cvt_ovf; logic cmp_unord;
    logic div_zero; logic log_zero; logic ovf; logic tiny; logic acc_loss;
    logic rnd_inexact; logic sincos; logic sincos_exact;
  } arith_ev_s;
  typedef struct packed {
    logic [3:0] opcode_hi; logic prec_hi; logic [2:0] src_a;
    logic opcode_mid; logic [2:0] dest; logic prec_lo;
    logic [1:0] round_method; logic opcode_lo; logic [3:0] src_b;
  } bounce_s;
endpackage

// ===== verilog/fpx_link_if.sv
// Command and answer path between host core and the exception unit
`timescale 1ns/1ps
interface fpx_link_if;
  import fpx_pkg::*;
  cmd_e  cmd;
  word_t wdata;
  logic  user_mode;
  logic  legacy_sel;
  word_t rdata;
  logic  done;
  logic  priv_trap;
  logic  exc_trap;
  logic  carry_flag;
  modport host (output cmd, wdata, user_mode, legacy_sel,
                input rdata, done, priv_trap, exc_trap, carry_flag);
  modport dev  (input cmd, wdata, user_mode, legacy_sel,
                output rdata, done, priv_trap, exc_trap, carry_flag);
endinterface

// ===== verilog/fp_exception_control.sv
// Device end: sticky flags, traps, compare carry and control registers
`timescale 1ns/1ps
`include "fpx_defines.svh"
module fp_exception_control (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  fpx_link_if.dev               link,
  input  wire logic             ev_valid_i,
  input  wire fpx_pkg::arith_ev_s ev_i,
  input  wire logic             ev_sign_i,
  input  wire logic             ev_async_i,
  input  wire logic             cmp_valid_i,
  input  wire fpx_pkg::cmp_e    cmp_i,
  input  wire logic             rem_partial_i,
  input  wire logic             bounce_sync_i,
  input  wire logic             bounce_async_i,
  input  wire logic             bounce_round_i,
  input  wire fpx_pkg::bounce_s bounce_i,
  input  wire logic [3:0]       round_status_i,
  output logic [31:0]           cvt_sat_o,
  output logic                  ovf_to_inf_o,
  output logic                  zero_result_o,
  output logic                  unit_enable_o,
  output logic                  legacy_unit_off_o
);
  import fpx_pkg::*;

  typedef struct packed {
    word_t status;
    word_t lcr;
    word_t acr;
    logic  carry;
    word_t rdata;
    logic  done;
    logic  priv_trap;
    logic  exc_trap;
    logic  [31:0] cvt_sat;
    logic  ovf_inf;
    logic  zero_res;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic [`FLG_W-1:0] raise;
  logic [`FLG_W-1:0] trap_en;
  logic              ctrl_op;
  logic              ctrl_bad;

  // Pack the bounced instruction into its control register positions
  function automatic word_t pack_bounce(bounce_s b);
    word_t w;
    w = 32'h0000_0000;
    w[23:20] = b.opcode_hi;
    w[19]    = b.prec_hi;
    w[18:16] = b.src_a;
    w[15]    = b.opcode_mid;
    w[14:12] = b.dest;
    w[7]     = b.prec_lo;
    w[6:5]   = b.round_method;
    w[4]     = b.opcode_lo;
    w[3:0]   = b.src_b;
    return w;
  endfunction

  // Classify arithmetic events into the five exception causes
  always_comb begin
    trap_en = st_reg.status[`STAT_TRAP_MSB:`STAT_TRAP_LSB];
    raise = '0;
    if (ev_valid_i) begin
      raise[`FLG_INV] = ev_i.trap_nan | ev_i.inf_sub | ev_i.zero_x_inf |
                        ev_i.div_indet | ev_i.rem_bad | ev_i.sqrt_neg |
                        ev_i.cvt_ovf | ev_i.cmp_unord;
      raise[`FLG_DVZ] = ev_i.div_zero | ev_i.log_zero;
      raise[`FLG_OFL] = ev_i.ovf;
      // Tininess alone counts only with the trap armed
      raise[`FLG_UFL] = trap_en[`FLG_UFL] ? ev_i.tiny
                        : (ev_i.tiny & ev_i.acc_loss);
      raise[`FLG_INX] = ev_i.rnd_inexact |
                        (ev_i.sincos & ~ev_i.sincos_exact) |
                        (ev_i.ovf & ~trap_en[`FLG_OFL]) |
                        (ev_i.tiny & ev_i.acc_loss & ~trap_en[`FLG_UFL]);
      // Armed overflow or underflow trap wins over inexact
      if ((raise[`FLG_OFL] & trap_en[`FLG_OFL]) |
          (raise[`FLG_UFL] & trap_en[`FLG_UFL]))
        raise[`FLG_INX] = 1'b0;
    end
    ctrl_op  = (link.cmd == OP_READ_CONTROL) |
               (link.cmd == OP_WRITE_CONTROL);
    ctrl_bad = ctrl_op & link.user_mode;
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.priv_trap = 1'b0;
    st_next.exc_trap = 1'b0;
    // Status write first; event sets below win over a clear
    if (link.cmd == OP_WRITE_STATUS)
      st_next.status = link.wdata & `STAT_WMASK;
    st_next.status[`STAT_FLAGS_MSB:0] =
      st_next.status[`STAT_FLAGS_MSB:0] | raise;
    st_next.exc_trap = |(raise & trap_en);
    if (cmp_valid_i)
      st_next.carry = (cmp_i == CMP_GT) | (cmp_i == CMP_EQ) |
        ((cmp_i == CMP_UN) & st_reg.status[`STAT_AC_BIT]);
    if (ev_valid_i & ev_i.cvt_ovf)
      st_next.cvt_sat = ev_sign_i ? 32'h8000_0000
                                  : 32'h7FFF_FFFF;
    st_next.ovf_inf  = ev_valid_i & ev_i.ovf & ~trap_en[`FLG_OFL];
    st_next.zero_res = ev_valid_i & ev_i.tiny & ~ev_i.acc_loss &
                       ~trap_en[`FLG_UFL];
    // Accelerator bounce capture
    if (bounce_sync_i | bounce_async_i) begin
      st_next.acr = (st_reg.acr & `ACR_WMASK) | pack_bounce(bounce_i);
      st_next.acr[`ACR_RE_BIT] = bounce_async_i & bounce_round_i;
      st_next.acr[`ACR_RU_BIT] = round_status_i[3];
      st_next.acr[`ACR_IE_BIT] = round_status_i[2];
      st_next.acr[`ACR_MO_BIT] = round_status_i[1];
      st_next.acr[`ACR_EO_BIT] = round_status_i[0];
    end
    // Host commands
    if (link.cmd != OP_NONE) begin
      st_next.done = 1'b1;
      if (ctrl_bad)
        st_next.priv_trap = 1'b1;
      else case (link.cmd)
        OP_READ_STATUS: begin
          st_next.rdata = st_reg.status;
        end
        OP_WRITE_STATUS: begin
        end
        OP_READ_CONTROL: begin
          if (link.legacy_sel)
            st_next.rdata = st_reg.lcr;
          else begin
            st_next.rdata = st_reg.acr;
            // Read is destructive; a bounce this cycle still sets
            if (!(bounce_sync_i | bounce_async_i))
              st_next.acr = st_reg.acr & ~`ACR_SB_AB_MASK;
          end
        end
        OP_WRITE_CONTROL: begin
          if (link.legacy_sel)
            st_next.lcr = link.wdata & `LCR_WMASK;
          else
            st_next.acr[`ACR_EN_BIT] = link.wdata[`ACR_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    // Hardware sets come last so they win over a same-cycle control write
    if (rem_partial_i)
      st_next.lcr[`LCR_PR_BIT] = 1'b1;
    if (|raise) begin
      st_next.lcr[`LCR_EX_BIT] = 1'b1;
      st_next.lcr[`LCR_AS_BIT] = ev_async_i;
    end
    if (bounce_sync_i)
      st_next.acr[`ACR_SB_BIT] = 1'b1;
    if (bounce_async_i)
      st_next.acr[`ACR_AB_BIT] = 1'b1;
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.status <= `STAT_RESET;
      st_reg.lcr <= `LCR_RESET;
      st_reg.acr <= `ACR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.rdata      = st_reg.rdata;
  assign link.done       = st_reg.done;
  assign link.priv_trap  = st_reg.priv_trap;
  assign link.exc_trap   = st_reg.exc_trap;
  assign link.carry_flag = st_reg.carry;
  assign cvt_sat_o         = st_reg.cvt_sat;
  assign ovf_to_inf_o      = st_reg.ovf_inf;
  assign zero_result_o     = st_reg.zero_res;
  assign unit_enable_o     = st_reg.acr[`ACR_EN_BIT];
  assign legacy_unit_off_o = st_reg.lcr[`LCR_OFF_BIT];
endmodule

// ===== verilog/fp_host_port.sv
// Host end: issues coprocessor commands and collects answers and traps
`timescale 1ns/1ps
`include "fpx_defines.svh"
module fp_host_port (
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  fpx_link_if.host           link,
  input  wire logic          req_i,
  input  wire fpx_pkg::cmd_e req_cmd_i,
  input  wire fpx_pkg::word_t req_wdata_i,
  input  wire logic          req_user_i,
  input  wire logic          req_legacy_i,
  output logic               busy_o,
  output logic               resp_valid_o,
  output fpx_pkg::word_t     resp_data_o,
  output logic               resp_priv_trap_o,
  output logic               exc_trap_o,
  output logic               carry_o
);
  import fpx_pkg::*;

  typedef enum logic {IDLE, WAIT} hstate_e;
  typedef struct packed {
    hstate_e st;
    cmd_e    cmd;
    word_t   wdata;
    logic    user;
    logic    legacy;
    logic    rv;
    word_t   rd;
    logic    pt;
  } hstate_s;

  hstate_s s_reg;
  hstate_s s_next;

  // Keep reserved bits zero on writes to protect future use
  function automatic word_t clean(cmd_e c, logic leg, word_t w);
    word_t r;
    r = w;
    if (c == OP_WRITE_STATUS)
      r = w & `STAT_WMASK;
    else if (c == OP_WRITE_CONTROL)
      r = leg ? (w & `LCR_WMASK) : (w & `ACR_WMASK);
    // Inexact trap left off, its behaviour varies between units
    if (c == OP_WRITE_STATUS)
      r[`STAT_TRAP_LSB + `FLG_INX] = 1'b0;
    return r;
  endfunction

  // One command in flight; held one cycle on the link
  always_comb begin
    s_next = s_reg;
    s_next.rv = 1'b0;
    case (s_reg.st)
      IDLE: begin
        s_next.cmd = OP_NONE;
        if (req_i && req_cmd_i != OP_NONE) begin
          s_next.st = WAIT;
          s_next.cmd = req_cmd_i;
          s_next.wdata = clean(req_cmd_i, req_legacy_i, req_wdata_i);
          s_next.user = req_user_i;
          s_next.legacy = req_legacy_i;
        end
      end
      WAIT: begin
        s_next.cmd = OP_NONE;
        if (link.done) begin
          s_next.st = IDLE;
          s_next.rv = 1'b1;
          s_next.rd = link.rdata;
          s_next.pt = link.priv_trap;
        end
      end
      default: begin
        s_next.st = IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign link.cmd        = s_reg.cmd;
  assign link.wdata      = s_reg.wdata;
  assign link.user_mode  = s_reg.user;
  assign link.legacy_sel = s_reg.legacy;
  assign busy_o           = (s_reg.st != IDLE);
  assign resp_valid_o     = s_reg.rv;
  assign resp_data_o      = s_reg.rd;
  assign resp_priv_trap_o = s_reg.pt;
  assign exc_trap_o       = link.exc_trap;
  assign carry_o          = link.carry_flag;
endmodule

// ===== sim/fp_exception_control_sva.sv
// Concurrent checks on the link between host end and exception unit
`timescale 1ns/1ps
`include "fpx_defines.svh"
module fp_exception_control_sva (
  input  wire logic           clk_i,
  input  wire logic           nrst_i,
  input  wire fpx_pkg::cmd_e  cmd,
  input  wire fpx_pkg::word_t wdata,
  input  wire logic           user_mode,
  input  wire logic           legacy_sel,
  input  wire fpx_pkg::word_t rdata,
  input  wire logic           done,
  input  wire logic           priv_trap,
  input  wire logic           exc_trap,
  input  wire logic           carry_flag
);
  import fpx_pkg::*;
  logic       en_reg;
  logic [4:0] flags_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Shadows: last enable written, and flags that must not fall back
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_reg    <= 1'b0;
      flags_reg <= 5'h00;
    end else begin
      if (cmd == OP_WRITE_CONTROL && !user_mode && !legacy_sel)
        en_reg <= wdata[`ACR_EN_BIT];
      if (cmd == OP_WRITE_STATUS)
        flags_reg <= wdata[4:0];
      else if (done && $past(cmd) == OP_READ_STATUS)
        flags_reg <= rdata[4:0];
    end
  end
  // Request and answer steps of one link transfer
  sequence s_any_req;
    cmd != OP_NONE;
  endsequence
  sequence s_answer;
    done ##1 !done;
  endsequence
  sequence s_user_ctrl;
    cmd inside {OP_READ_CONTROL, OP_WRITE_CONTROL} && user_mode;
  endsequence
  property p_answer;
    s_any_req |=> s_answer;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no single answer pulse after a request");
  property p_no_stray;
    done |-> $past(cmd) != OP_NONE;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("answer without a request");
  property p_priv_trap;
    s_user_ctrl |=> priv_trap && done;
  endproperty
  a_priv_trap: assert property (p_priv_trap)
    else $error("user control access did not trap");
  property p_no_priv;
    cmd inside {OP_READ_STATUS, OP_WRITE_STATUS}
      || (cmd != OP_NONE && !user_mode) |=> !priv_trap;
  endproperty
  a_no_priv: assert property (p_no_priv)
    else $error("privilege trap on a legal access");
  property p_stat_resv;
    done && $past(cmd) == OP_READ_STATUS
      |-> (rdata & ~`STAT_WMASK) == 32'h0000_0000;
  endproperty
  a_stat_resv: assert property (p_stat_resv)
    else $error("status reserved bits not zero");
  property p_lcr_resv;
    done && $past(cmd) == OP_READ_CONTROL && $past(legacy_sel)
      && !$past(user_mode) |-> (rdata & ~`LCR_WMASK) == 32'h0000_0000;
  endproperty
  a_lcr_resv: assert property (p_lcr_resv)
    else $error("legacy control reserved bits not zero");
  property p_acr_en;
    done && $past(cmd) == OP_READ_CONTROL && !$past(legacy_sel)
      && !$past(user_mode) |-> rdata[`ACR_EN_BIT] == en_reg;
  endproperty
  a_acr_en: assert property (p_acr_en)
    else $error("enable bit differs from last write");
  property p_sticky;
    done && $past(cmd) == OP_READ_STATUS
      |-> (rdata[4:0] & flags_reg) == flags_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("a flag cleared without a status write");
endmodule

// ===== sim/fp_exception_control_test.sv
// Self-checking bench: host end and exception unit joined over the link
`timescale 1ns/1ps
module fp_exception_control_test;
  import fpx_pkg::*;
  logic       clk_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0, pt, tr, zr, oi;
  cmd_e       req_cmd_i = OP_NONE;
  word_t      req_wdata_i = 32'h0000_0000, rd, w, cvt_sat_o, resp_data_o;
  logic       req_user_i = 1'b0, req_legacy_i = 1'b0, ev_valid_i = 1'b0;
  logic       ev_sign_i = 1'b1, ev_async_i = 1'b0, cmp_valid_i = 1'b0;
  logic       rem_partial_i = 1'b0, bounce_sync_i = 1'b0;
  logic       bounce_async_i = 1'b0, bounce_round_i = 1'b0;
  arith_ev_s  ev_i = 16'h0000;
  cmp_e       cmp_i = CMP_LT;
  bounce_s    bounce_i = 20'hB_5A6D;
  logic [3:0] round_status_i = 4'hB;
  logic       busy_o, resp_valid_o, resp_priv_trap_o, exc_trap_o, carry_o;
  logic       ovf_to_inf_o, zero_result_o, unit_enable_o, legacy_unit_off_o;
  int         errors = 0, checks = 0, cycles = 0;
  // Rows: event [31:16], trap enables [12:8], trap [7], flags [4:0]
  word_t      tab [18] = '{32'h8000_0001, 32'h4000_0181, 32'h2000_0001,
    32'h1000_0001, 32'h0800_0001, 32'h0400_0001, 32'h0200_0001,
    32'h0100_0001, 32'h0080_0282, 32'h0040_0002, 32'h0020_0014,
    32'h0020_0484, 32'h0010_0000, 32'h0018_0018, 32'h0010_0888,
    32'h0004_0010, 32'h0002_0010, 32'h0003_0000};
  fpx_link_if fpx_link_if_i ();
  fp_host_port fp_host_port_i (.clk_i, .nrst_i, .link(fpx_link_if_i), .req_i,
    .req_cmd_i, .req_wdata_i, .req_user_i, .req_legacy_i, .busy_o,
    .resp_valid_o, .resp_data_o, .resp_priv_trap_o, .exc_trap_o, .carry_o);
  fp_exception_control fp_exception_control_i (.clk_i, .nrst_i,
    .link(fpx_link_if_i), .ev_valid_i, .ev_i, .ev_sign_i, .ev_async_i,
    .cmp_valid_i, .cmp_i, .rem_partial_i, .bounce_sync_i, .bounce_async_i,
    .bounce_round_i, .bounce_i, .round_status_i, .cvt_sat_o, .ovf_to_inf_o,
    .zero_result_o, .unit_enable_o, .legacy_unit_off_o);
  fp_exception_control_sva fp_exception_control_sva_i (.clk_i, .nrst_i,
    .cmd(fpx_link_if_i.cmd), .wdata(fpx_link_if_i.wdata),
    .user_mode(fpx_link_if_i.user_mode), .legacy_sel(fpx_link_if_i.legacy_sel),
    .rdata(fpx_link_if_i.rdata), .done(fpx_link_if_i.done),
    .priv_trap(fpx_link_if_i.priv_trap), .exc_trap(fpx_link_if_i.exc_trap),
    .carry_flag(fpx_link_if_i.carry_flag));
  always #5 clk_i = ~clk_i;
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input word_t seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One host request; host keeps one in flight, so wait for its answer
  task automatic op(input cmd_e c, input word_t wd, input logic u, l);
    int n;
    n = 0;
    @(negedge clk_i);
    req_i = 1'b1;
    req_cmd_i = c;
    req_wdata_i = wd;
    req_user_i = u;
    req_legacy_i = l;
    @(negedge clk_i);
    req_i = 1'b0;
    check("busy", {31'h0, busy_o}, 32'h0000_0001);
    while (resp_valid_o !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    check("answer", {31'h0, resp_valid_o}, 32'h0000_0001);
    check("idle", {31'h0, busy_o}, 32'h0000_0000);
    rd = resp_data_o;
    pt = resp_priv_trap_o;
  endtask
  // One arithmetic event; trap and zero pulses caught over two cycles
  task automatic ev(input logic [15:0] e, input logic a);
    @(negedge clk_i);
    ev_valid_i = 1'b1;
    ev_i = e;
    ev_async_i = a;
    @(negedge clk_i);
    ev_valid_i = 1'b0;
    tr = exc_trap_o;
    zr = zero_result_o;
    oi = ovf_to_inf_o;
    @(negedge clk_i);
    tr = tr | exc_trap_o;
    zr = zr | zero_result_o;
    oi = oi | ovf_to_inf_o;
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b1;
    op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b0);
    check("acr reset", rd, 32'h0000_0000);
    op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b1);
    check("lcr reset", rd, 32'h0000_0000);
    op(OP_WRITE_CONTROL, 32'h0000_0100, 1'b1, 1'b0);
    check("user trap", {31'h0, pt}, 32'h0000_0001);
    check("enable", {31'h0, unit_enable_o}, 32'h0000_0000);
    op(OP_READ_STATUS, 32'h0000_0000, 1'b1, 1'b0);
    check("user status", {31'h0, pt}, 32'h0000_0000);
    op(OP_WRITE_CONTROL, 32'h0000_0100, 1'b0, 1'b0);
    op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b0);
    check("acr en", rd, 32'h0000_0100);
    check("enable", {31'h0, unit_enable_o}, 32'h0000_0001);
    $display("test control done");
    // Inexact trap stays off throughout, as software should keep it
    for (int i = 0; i < 18; i++) begin
      w = tab[i];
      op(OP_WRITE_STATUS, {11'h000, w[12:8], 16'h0000}, 1'b0, 1'b0);
      ev(w[31:16], 1'b0);
      check("trap", {31'h0, tr}, {31'h0, w[7]});
      if (i == 6) check("sat", cvt_sat_o, 32'h8000_0000);
      if (i == 12) check("zero", {31'h0, zr}, 32'h0000_0001);
      if (i == 10) check("to inf", {31'h0, oi}, 32'h0000_0001);
      if (i == 11) check("no inf", {31'h0, oi}, 32'h0000_0000);
      op(OP_READ_STATUS, 32'h0000_0000, 1'b0, 1'b0);
      check("status", rd, {11'h000, w[12:8], 11'h000, w[4:0]});
    end
    op(OP_WRITE_STATUS, 32'h0000_0000, 1'b0, 1'b0);
    ev(16'h8000, 1'b0);
    ev(16'h0040, 1'b0);
    ev_sign_i = 1'b0;
    ev(16'h0200, 1'b0);
    check("sat pos", cvt_sat_o, 32'h7FFF_FFFF);
    repeat (2) begin
      op(OP_READ_STATUS, 32'h0000_0000, 1'b0, 1'b0);
      check("sticky", rd, 32'h0000_0003);
    end
    $display("test flags done");
    for (int a = 0; a < 2; a++) begin
      op(OP_WRITE_STATUS, a ? 32'h0000_1000 : 32'h0000_0000, 1'b0, 1'b0);
      for (int c = 0; c < 4; c++) begin
        @(negedge clk_i);
        cmp_valid_i = 1'b1;
        cmp_i = cmp_e'(c);
        @(negedge clk_i);
        cmp_valid_i = 1'b0;
        @(negedge clk_i);
        tr = c == 1 || c == 2 || a + c == 4;
        check("carry", {31'h0, carry_o}, {31'h0, tr});
      end
    end
    $display("test carry done");
    // Sync bounce first; each bounce rewrites the rounding mark, clear for sync and set for async with rounding
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      bounce_sync_i = (k == 0);
      bounce_async_i = (k == 1);
      bounce_round_i = (k == 1);
      @(negedge clk_i);
      bounce_sync_i = 1'b0;
      bounce_async_i = 1'b0;
      w = k ? 32'h8CB5_A36D : 32'h8CB5_A16D;
      op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b0);
      check("bounce", rd, w | (k ? 32'h0000_0400 : 32'h0000_0800));
      op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b0);
      check("cleared", rd, w);
    end
    $display("test bounce done");
    op(OP_WRITE_CONTROL, 32'h0000_00F7, 1'b0, 1'b1);
    op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b1);
    check("lcr", rd, 32'h0000_00F7);
    check("off", {31'h0, legacy_unit_off_o}, 32'h0000_0001);
    op(OP_WRITE_CONTROL, 32'h0000_0000, 1'b0, 1'b1);
    @(negedge clk_i);
    rem_partial_i = 1'b1;
    @(negedge clk_i);
    rem_partial_i = 1'b0;
    ev(16'h8000, 1'b1);
    op(OP_READ_CONTROL, 32'h0000_0000, 1'b0, 1'b1);
    check("lcr events", rd, 32'h0000_0086);
    $display("test legacy done");
    end_of_test();
  end
endmodule
